// [src/adc_ctrl_pkg.sv]
/*
 * Package for the converter configuration and result correction block:
 * register byte addresses, field positions, reset values, timing constants
 * and the conversion state encoding.
 * Assumes a 250 MHz APB clock and a 32-bit APB address bus.
 */
package adc_ctrl_pkg;

   // Register byte addresses
   localparam logic [31:0] RESULT_ADDR      = 32'h4000D000;
   localparam logic [31:0] CONFIG_ADDR      = 32'h4000D004;
   localparam logic [31:0] OFFSET_ADDR      = 32'h4000D008;
   localparam logic [31:0] GAIN_ADDR        = 32'h4000D00C;
   localparam logic [31:0] STATUS_ADDR      = 32'h4000D030;

   // Configuration field positions
   localparam int PERIOD_HI         = 15;
   localparam int PERIOD_LO         = 13;
   localparam int POS_SEL_HI        = 10;
   localparam int POS_SEL_LO        = 7;
   localparam int NEG_SEL_HI        = 6;
   localparam int NEG_SEL_LO        = 3;
   localparam int SLOW_CLK_BIT      = 2;
   localparam int ENABLE_BIT        = 0;

   // Status field positions
   localparam int ST_CONVERTING_BIT = 0;
   localparam int ST_STARTUP_BIT    = 1;
   localparam int ST_POS_BAD_BIT    = 2;
   localparam int ST_NEG_BAD_BIT    = 3;
   localparam int ST_DOUBLE_BIT     = 4;

   // Reset values
   localparam logic [15:0] CONFIG_RESET     = 16'h0000;
   localparam logic [15:0] OFFSET_RESET     = 16'h0000;
   localparam logic [15:0] GAIN_RESET       = 16'h8000;
   localparam logic [15:0] RESULT_RESET     = 16'h0000;

   // Conversion length and resolution
   localparam logic [13:0] BASE_PERIOD_CLOCKS = 14'h0020;
   localparam logic [3:0]  MAX_LOW_ZERO_BITS  = 4'h9;

   // Input source codes
   localparam logic [3:0]  SRC_LAST_PIN     = 4'h5;
   localparam logic [3:0]  SRC_GROUND       = 4'h8;
   localparam logic [3:0]  SRC_HALF_REF     = 4'h9;
   localparam logic [3:0]  SRC_FULL_REF     = 4'hA;
   localparam logic [3:0]  SRC_HALF_SUPPLY  = 4'hB;

   // Timing
   localparam int PCLK_HZ            = 250_000_000;
   localparam int PCLK_PERIOD_NS     = 4;
   localparam int FAST_CONV_HZ       = 6_000_000;
   localparam int SLOW_CONV_HZ       = 1_000_000;
   localparam logic [7:0] FAST_DIV_LAST = 8'(PCLK_HZ / FAST_CONV_HZ - 1);
   localparam logic [7:0] SLOW_DIV_LAST = 8'(PCLK_HZ / SLOW_CONV_HZ - 1);
   localparam int STARTUP_NS         = 21000;
   localparam int STARTUP_CYCLES_DEF = (STARTUP_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_STARTUP = 3'b010,
      ST_CONVERT = 3'b100
   } conv_state_e;

endpackage : adc_ctrl_pkg

// [src/adc_config_and_correction.sv]
/*
 * Converter configuration and result correction block: APB register slave,
 * conversion timing, input routing to the analog core, and offset/gain
 * correction of each raw result.
 * Assumes the analog core presents a left-aligned signed raw result on
 * raw_result while conversion_done is high, and all inputs are synchronous
 * to pclk.
 */
// Local design decision: register access over APB.
//
// Summary of operation
// - Period field bits 15:13 picks 32 up to 4096 converter clocks per sample.
// - Each period code yields 7 plus code significant result bits.
// - Positive input field bits 10:7; codes 0 to 5 pick six port pins.
// - Codes 8 to B pick ground, half reference, reference, half pad supply.
// - Negative input field bits 6:3 uses the same source mapping.
// - Bit 2 clear gives 6 MHz converter clock, set gives 1 MHz.
// - Bit 0 set runs conversions back to back; clearing it stops them.
// - First conversion after switch-on takes double clocks plus 21 us.
// - A configuration write while running doubles the next conversion.
// - Signed 16-bit offset is added to each raw result before gain.
// - Offset-corrected result is multiplied by the gain value.
// - Gain is unsigned with binary point between bits 15 and 14.
// - Gain resets to 8000 hex, offset resets to zero.
// - Result is signed 16-bit with significant bits left-aligned from bit 15.
`timescale 1ns/1ps

module adc_config_and_correction
   import adc_ctrl_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog core
   input  wire logic        high_voltage_range,
   input  wire logic [15:0] raw_result,
   output logic      [3:0]  positive_input_select,
   output logic      [3:0]  negative_input_select,
   output logic             slow_clock_select,
   output logic             converter_on,
   output logic             converter_clock_tick,
   output logic             conversion_done,
   // Corrected result
   output logic      [15:0] result_data,
   output logic             result_valid
);

   // Source code valid for the present range
   function automatic logic select_valid(input logic [3:0] code, input logic hv);
      logic ok;
      ok = (code <= SRC_LAST_PIN) || (code == SRC_HALF_REF) || (code == SRC_FULL_REF);
      if (!hv && ((code == SRC_GROUND) || (code == SRC_HALF_SUPPLY))) begin
         ok = 1'b1;
      end
      return ok;
   endfunction : select_valid

   // Mask keeping 7 plus period significant bits from bit 15
   function automatic logic [15:0] result_mask(input logic [2:0] period);
      logic [3:0] low_zeros;
      low_zeros = MAX_LOW_ZERO_BITS - {1'b0, period};
      return 16'hFFFF << low_zeros;
   endfunction : result_mask

   logic [15:0]  config_reg;
   logic [15:0]  offset_reg;
   logic [15:0]  gain_reg;
   logic [15:0]  result_reg;
   logic [15:0]  raw_reg;
   logic         raw_valid_reg;
   logic         result_valid_reg;
   logic [31:0]  prdata_reg;
   logic         pready_reg;
   logic         pslverr_reg;
   conv_state_e  state_reg;
   logic [13:0]  count_reg;
   logic [7:0]   div_reg;
   logic         double_reg;
   logic         pending_reg;
   logic         done_reg;
   logic         tick_reg;

   // Bus decode
   wire          hit_result  = (paddr == RESULT_ADDR);
   wire          hit_config  = (paddr == CONFIG_ADDR);
   wire          hit_offset  = (paddr == OFFSET_ADDR);
   wire          hit_gain    = (paddr == GAIN_ADDR);
   wire          hit_status  = (paddr == STATUS_ADDR);
   wire          mapped      = hit_result | hit_config | hit_offset | hit_gain | hit_status;
   wire          access_new  = psel & penable & ~pready_reg;
   wire          complete    = psel & penable & pready_reg;
   wire          write_fire  = complete & pwrite & mapped;
   wire          config_wr   = write_fire & hit_config;

   // Configuration fields
   wire [2:0]    period      = config_reg[PERIOD_HI:PERIOD_LO];
   wire          enabled     = config_reg[ENABLE_BIT];
   wire          wr_enable   = pwdata[ENABLE_BIT];
   wire          pos_ok      = select_valid(config_reg[POS_SEL_HI:POS_SEL_LO], high_voltage_range);
   wire          neg_ok      = select_valid(config_reg[NEG_SEL_HI:NEG_SEL_LO], high_voltage_range);

   // Status word
   wire [4:0]    status_bits;
   assign status_bits[ST_CONVERTING_BIT] = (state_reg == ST_CONVERT);
   assign status_bits[ST_STARTUP_BIT]    = (state_reg == ST_STARTUP);
   assign status_bits[ST_POS_BAD_BIT]    = ~pos_ok;
   assign status_bits[ST_NEG_BAD_BIT]    = ~neg_ok;
   assign status_bits[ST_DOUBLE_BIT]     = double_reg | pending_reg;

   wire [31:0]   read_mux    = hit_result ? {16'h0000, result_reg} :
                               hit_config ? {16'h0000, config_reg} :
                               hit_offset ? {16'h0000, offset_reg} :
                               hit_gain   ? {16'h0000, gain_reg}   :
                               hit_status ? {27'h0000000, status_bits} : 32'h00000000;

   // Conversion timing
   wire [13:0]   conv_len    = BASE_PERIOD_CLOCKS << period;
   wire [13:0]   conv_target = double_reg ? (conv_len << 1) : conv_len;
   wire [7:0]    div_last    = config_reg[SLOW_CLK_BIT] ? SLOW_DIV_LAST : FAST_DIV_LAST;
   wire          conv_tick   = (state_reg == ST_CONVERT) && (div_reg == div_last);
   wire          conv_end    = conv_tick && (count_reg == conv_target - 14'h0001);
   wire          startup_end = (state_reg == ST_STARTUP) &&
                               (count_reg == 14'(STARTUP_CYCLES - 1));
   wire          running_wr  = config_wr && wr_enable && (state_reg == ST_CONVERT);

   // Correction arithmetic
   wire signed [16:0] offset_sum = $signed({raw_reg[15], raw_reg}) +
                                   $signed({offset_reg[15], offset_reg});
   wire signed [33:0] product    = offset_sum * $signed({1'b0, gain_reg});
   wire signed [18:0] scaled     = product[33:15];
   wire          fits        = (scaled[18:15] == 4'h0) || (scaled[18:15] == 4'hF);
   wire [15:0]   saturated   = fits ? scaled[15:0] :
                               (scaled[18] ? 16'h8000 : 16'h7FFF);
   wire [15:0]   corrected   = saturated & result_mask(period);

   // APB answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= access_new;
         pslverr_reg <= access_new & ~mapped;
         if (access_new) begin
            prdata_reg <= read_mux;
         end
      end
   end

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= CONFIG_RESET;
         offset_reg <= OFFSET_RESET;
         gain_reg   <= GAIN_RESET;
      end else begin
         if (config_wr) begin
            config_reg <= pwdata[15:0];
         end
         if (write_fire && hit_offset) begin
            offset_reg <= pwdata[15:0];
         end
         if (write_fire && hit_gain) begin
            gain_reg <= pwdata[15:0];
         end
      end
   end

   // Conversion sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= ST_IDLE;
         count_reg   <= 14'h0000;
         div_reg     <= 8'h00;
         double_reg  <= 1'b0;
         pending_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               count_reg <= 14'h0000;
               div_reg   <= 8'h00;
               if (config_wr && wr_enable) begin
                  state_reg  <= ST_STARTUP;
                  double_reg <= 1'b1;
               end
            end
            ST_STARTUP: begin
               count_reg <= count_reg + 14'h0001;
               if (config_wr && !wr_enable) begin
                  state_reg <= ST_IDLE;
               end else if (startup_end) begin
                  state_reg <= ST_CONVERT;
                  count_reg <= 14'h0000;
               end
            end
            ST_CONVERT: begin
               div_reg <= conv_tick ? 8'h00 : div_reg + 8'h01;
               if (config_wr && !wr_enable) begin
                  state_reg   <= ST_IDLE;
                  double_reg  <= 1'b0;
                  pending_reg <= 1'b0;
               end else if (conv_end) begin
                  count_reg   <= 14'h0000;
                  double_reg  <= pending_reg | running_wr;
                  pending_reg <= 1'b0;
               end else begin
                  if (conv_tick) begin
                     count_reg <= count_reg + 14'h0001;
                  end
                  if (running_wr) begin
                     pending_reg <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Core strobes and result pipeline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg         <= 1'b0;
         done_reg         <= 1'b0;
         raw_reg          <= RESULT_RESET;
         raw_valid_reg    <= 1'b0;
         result_reg       <= RESULT_RESET;
         result_valid_reg <= 1'b0;
      end else begin
         tick_reg      <= conv_tick;
         done_reg      <= conv_end && enabled;
         raw_valid_reg <= done_reg;
         if (done_reg) begin
            raw_reg <= raw_result;
         end
         result_valid_reg <= raw_valid_reg;
         if (raw_valid_reg) begin
            result_reg <= corrected;
         end
      end
   end

   assign prdata                = prdata_reg;
   assign pready                = pready_reg;
   assign pslverr               = pslverr_reg;
   assign positive_input_select = config_reg[POS_SEL_HI:POS_SEL_LO];
   assign negative_input_select = config_reg[NEG_SEL_HI:NEG_SEL_LO];
   assign slow_clock_select     = config_reg[SLOW_CLK_BIT];
   assign converter_on          = enabled;
   assign converter_clock_tick  = tick_reg;
   assign conversion_done       = done_reg;
   assign result_data           = result_reg;
   assign result_valid          = result_valid_reg;

endmodule : adc_config_and_correction

// [tb/adc_core_model.sv]
/* Analog core stand-in: presents a left-aligned signed sample.
   Assumes pclk and presetn of the converter block. */
`timescale 1ns/1ps
module adc_core_model (
   // Clock, reset and control
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        converter_on,
   // Sample from the bench and raw output
   input  wire logic [15:0] sample_value,
   output logic      [15:0] raw_result
);
   logic [15:0] last_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) last_reg <= 16'h0000;
      else if (converter_on) last_reg <= sample_value;
   end
   // Off: inverse of last value, never a held copy
   assign raw_result = converter_on ? sample_value : ~last_reg;
endmodule : adc_core_model

// [tb/adc_config_and_correction_sva.sv]
/* Port checker for the converter block.
   Assumes one pclk domain with presetn active low. */
`timescale 1ns/1ps
module adc_config_and_correction_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        slow_clock_select,
   input wire logic        converter_on,
   input wire logic        converter_clock_tick,
   input wire logic        conversion_done,
   input wire logic        result_valid,
   input wire logic [15:0] result_data
);
   logic [8:0] gap_reg;
   logic       seen_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gap_reg <= 9'h000;
      else if (converter_clock_tick) gap_reg <= 9'h000;
      else if (gap_reg != 9'h1FF) gap_reg <= gap_reg + 9'h001;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) seen_reg <= 1'b0;
      else if (converter_clock_tick) seen_reg <= 1'b1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_valid_after_done: assert property (conversion_done |-> ##2 result_valid)
      else $error("result late");
   a_valid_has_cause: assert property (result_valid |-> $past(conversion_done, 2))
      else $error("result without conversion");
   a_done_when_on: assert property (conversion_done |-> $past(converter_on))
      else $error("conversion while off");
   a_tick_rate: assert property (converter_clock_tick && seen_reg |->
      gap_reg >= (slow_clock_select ? 9'h0F9 : 9'h028)) else $error("tick too soon");
   a_data_holds: assert property (result_data != $past(result_data) |-> result_valid)
      else $error("result changed");
   c_result: cover property (result_valid);
   c_refused: cover property (pslverr);
   c_slow_tick: cover property (converter_clock_tick && slow_clock_select);
endmodule : adc_config_and_correction_chk

bind adc_config_and_correction adc_config_and_correction_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .slow_clock_select(slow_clock_select),
   .converter_on(converter_on), .converter_clock_tick(converter_clock_tick), .conversion_done(conversion_done),
   .result_valid(result_valid), .result_data(result_data));

// [tb/adc_config_and_correction_bench.sv]
/* Self-checking bench for the converter block.
   Assumes the core model and the bound checker. */
`timescale 1ns/1ps
module adc_config_and_correction_bench;
   import adc_ctrl_pkg::*;
   localparam int SU = 8;
   localparam int FT = int'(FAST_DIV_LAST) + 1;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, high_voltage_range, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [15:0] raw_result, sample_value, result_data;
   logic [3:0]  positive_input_select, negative_input_select;
   logic        slow_clock_select, converter_on, converter_clock_tick, conversion_done, result_valid;
   int          n_fail = 0, check_count = 0, cycles = 0, n;
   row_s        rows [5];

   adc_config_and_correction #(.STARTUP_CYCLES(SU)) u_adc_config_and_correction (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_voltage_range(high_voltage_range),
      .raw_result(raw_result), .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .slow_clock_select(slow_clock_select),
      .converter_on(converter_on), .converter_clock_tick(converter_clock_tick),
      .conversion_done(conversion_done), .result_data(result_data), .result_valid(result_valid));
   adc_core_model u_adc_core_model (.pclk(pclk), .presetn(presetn), .converter_on(converter_on),
      .sample_value(sample_value), .raw_result(raw_result));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 45000) begin
         n_fail++;
         end_of_test();
      end
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task chk_val(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk_val
   task chk_range(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask : chk_range
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task wait_done;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (conversion_done !== 1'b1 && n < 20000);
   endtask : wait_done
   task chk_result(input logic [15:0] raw, input logic [15:0] off, input logic [15:0] gain, input int p);
      longint v;
      int k;
      v = ((longint'($signed(raw)) + longint'($signed(off))) * longint'(gain)) >>> 15;
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (result_valid !== 1'b1 && k < 5);
      chk_val({16'h0000, result_data}, {16'h0000, 16'(v) & (16'hFFFF << (9 - p))});
   endtask : chk_result

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      high_voltage_range = 1'b0; sample_value = 16'h4000;
      rows[0] = '{OFFSET_ADDR, 32'hFFFF_8001, 32'h0000_8001, 1'b0};
      rows[1] = '{GAIN_ADDR, 32'h0001_C000, 32'h0000_C000, 1'b0};
      rows[2] = '{CONFIG_ADDR, 32'h0000_0540, 32'h0000_0540, 1'b0};
      rows[3] = '{CONFIG_ADDR, 32'h0000_E5CC, 32'h0000_E5CC, 1'b0};
      rows[4] = '{32'h4000_D010, 32'h0000_1234, 32'h0000_0000, 1'b1};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         chk_val(er, rows[i].e);
         apb(1'b0, rows[i].a, 32'h0);
         chk_val(rd, rows[i].x);
      end
      chk_val(positive_input_select, 4'hB);
      chk_val(negative_input_select, 4'h9);
      chk_val(slow_clock_select, 1'b1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk_val(rd, 32'h0000_0000);
      high_voltage_range <= 1'b1;
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk_val(rd, 32'h0000_0001 << ST_POS_BAD_BIT);
      high_voltage_range <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFFSET_ADDR, 32'h0);
      chk_val(rd, 32'h0000_0000);
      apb(1'b0, GAIN_ADDR, 32'h0);
      chk_val(rd, 32'h0000_8000);
      apb(1'b1, OFFSET_ADDR, 32'h0000_0100);
      apb(1'b1, CONFIG_ADDR, 32'h0000_0001);
      wait_done();
      chk_range(n, SU + 64 * FT, SU + 64 * FT + 2);
      chk_result(16'h4000, 16'h0100, 16'h8000, 0);
      sample_value <= 16'h7000;
      apb(1'b1, GAIN_ADDR, 32'h0000_FFFF);
      wait_done();
      chk_range(n, 32 * FT - 7, 32 * FT - 5);
      chk_result(16'h7000, 16'h0100, 16'hFFFF, 0);
      apb(1'b1, CONFIG_ADDR, 32'h0000_0001);
      sample_value <= 16'h8000;
      apb(1'b1, OFFSET_ADDR, 32'h0000_FFFF);
      wait_done();
      wait_done();
      chk_range(n, 64 * FT - 1, 64 * FT + 1);
      chk_result(16'h8000, 16'hFFFF, 16'hFFFF, 0);
      apb(1'b1, CONFIG_ADDR, 32'h0000_0000);
      @(posedge pclk);
      chk_val(converter_on, 1'b0);
      n = 0;
      repeat (1500) begin
         @(posedge pclk);
         if (conversion_done !== 1'b0) n++;
      end
      chk_range(n, 0, 0);
      sample_value <= 16'h1357;
      apb(1'b1, OFFSET_ADDR, 32'h0000_0000);
      apb(1'b1, CONFIG_ADDR, 32'h0000_2001);
      wait_done();
      chk_range(n, SU + 128 * FT, SU + 128 * FT + 2);
      chk_result(16'h1357, 16'h0000, 16'hFFFF, 1);
      apb(1'b1, CONFIG_ADDR, 32'h0000_0000);
      apb(1'b1, CONFIG_ADDR, 32'h0000_0005);
      wait_done();
      chk_range(n, SU + 15992, SU + 16008);
      end_of_test();
   end
endmodule : adc_config_and_correction_bench
